// File: fps_pkg.sv
package fps_pkg;
    // Oscillator rates
    localparam int unsigned OSC_HIGH_HZ = 8_000_000;
    localparam int unsigned OSC_LOW_DIV = 128;
    // Reference clock
    localparam int unsigned REF_CLK_HZ = 20_000_000;
    // Default frame interval in reference cycles (1/frame_rate)
    localparam int unsigned FRAME_CYCLES_DEF = 20_000;
    // Over-sample ratio limits
    localparam int unsigned OSR_MIN = 1;
    localparam int unsigned OSR_MAX = 4;
    // Oscillator modes
    typedef enum logic [1:0] {
        FPS_OSC_OFF = 2'h0,
        FPS_OSC_LOW = 2'h1,
        FPS_OSC_HIGH = 2'h2
    } fps_osc_t;
    // Frame phases, one-hot
    typedef enum logic [3:0] {
        FPS_PH_IDLE = 4'h1,
        FPS_PH_WAIT = 4'h2,
        FPS_PH_ANALOG = 4'h4,
        FPS_PH_DIGITAL = 4'h8
    } fps_phase_t;
    // Auxiliary channel selections
    localparam logic [1:0] AUX_TEMP = 2'h0;
    localparam logic [1:0] AUX_EXT0 = 2'h1;
    localparam logic [1:0] AUX_EXT1 = 2'h2;
endpackage : fps_pkg

// File: fps_frame_counter.sv
`timescale 1ns/1ps
`default_nettype none
// Frame interval counter: one-cycle start-of-frame pulse every frame
module fps_frame_counter
    import fps_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = FRAME_CYCLES_DEF
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_enable,
    output logic o_sof
);
    localparam int W = $clog2(FRAME_CYCLES);
    logic [W-1:0] cnt_reg;

    initial begin
        if (FRAME_CYCLES < 4) $error("FRAME_CYCLES too small");
    end

    // Free-running interval count, fixed length for all frames
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_reg <= '0;
        end else if (!i_enable) begin
            cnt_reg <= '0;
        end else if (cnt_reg == W'(FRAME_CYCLES - 1)) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign o_sof = i_enable && (cnt_reg == W'(FRAME_CYCLES - 1));

    property p_sof_spacing;
        @(posedge i_clk) disable iff (!i_arst_n)
        o_sof |=> !o_sof;
    endproperty
    a_sof_spacing: assert property (p_sof_spacing) else $error("sof back to back");
endmodule : fps_frame_counter
`default_nettype wire

// File: fps_frame_phase_sequencer.sv
// Notes on behaviour
// RULE1 - Frame counter pulse times every phase event
// RULE2 - Sample frame: frame start raises analog trigger
// RULE3 - Non-sample frame: frame start raises digital trigger
// RULE4 - Digital trigger only from frame start or analog end
// RULE5 - Analog front end signals analog end
// RULE6 - Started indications wait for high-speed oscillator
// RULE7 - CPU stops with slow stop bit for idle
// RULE8 - High-speed oscillator nominally 8 MHz, active phases
// RULE9 - Low speed is high speed divided by 128
// RULE10 - Digital phase bounded by frame minus analog
// RULE11 - Idle powers down, fills rest of frame
// RULE12 - Analog samples three axes plus one auxiliary; the code always enables the three axes and disables the auxiliary when the auxiliary select is 3
// RULE13 - CPU quiet during analog phase
// RULE14 - Digital phase: CPU active, analog low power
// RULE15 - Frame interval fixed, reciprocal of frame rate
// RULE16 - Output rate is sample rate over ratio
// RULE17 - One sample frame per sample period
// RULE18 - Any interrupt returns stop to run
// RULE19 - Over-sample ratio between 1 and 4
// RULE20 - Frame start requests high-speed oscillator
`timescale 1ns/1ps
`default_nettype none
module fps_frame_phase_sequencer
    import fps_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = FRAME_CYCLES_DEF,
    parameter int unsigned SAMPLE_DIV_MAX = 16
) (
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    input wire logic i_enable,
    input wire logic [4:0] i_sample_div,
    input wire logic [2:0] i_oversample_ratio,
    input wire logic [1:0] i_aux_sel,
    input wire logic i_analog_end,
    input wire logic i_osc_is_high,
    input wire logic i_cpu_stop,
    input wire logic i_slow_clock_stop_sel,
    input wire logic i_fast_clock_stop_sel,
    input wire logic i_irq,
    output logic o_start_analog,
    output logic o_start_digital,
    output logic o_analog_started,
    output logic o_digital_started,
    output logic o_osc_high_req,
    output logic o_osc_low_req,
    output logic o_cpu_quiet,
    output logic o_analog_lowpower,
    output logic o_power_down,
    output logic [3:0] o_chan_en,
    output logic o_output_ready,
    output logic o_digital_overrun
);
    fps_phase_t phase_reg;
    logic sof;
    logic [4:0] samp_cnt_reg;
    logic [2:0] osr_cnt_reg;
    logic sample_frame;
    logic pend_a_reg;
    logic pend_d_reg;
    logic osc_high_req_reg;
    logic osc_low_req_reg;
    logic analog_started_reg;
    logic digital_started_reg;
    logic output_ready_reg;
    logic overrun_reg;
    logic [3:0] chan_en_reg;
    logic stopped_fast_reg;
    logic start_a;
    logic start_d;
    logic [2:0] osr_eff;

    initial begin
        if (SAMPLE_DIV_MAX < 1 || SAMPLE_DIV_MAX > 31) $error("SAMPLE_DIV_MAX out of range");
    end

    // RULE1 frame interval counter
    // RULE15 fixed frame length
    fps_frame_counter #(
        .FRAME_CYCLES(FRAME_CYCLES)
    ) u_frame_counter (
        .i_clk(I_REF_CLK),
        .i_arst_n(I_ARST_N),
        .i_enable(i_enable),
        .o_sof(sof)
    );

    // RULE17 one sample frame per sample period
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            samp_cnt_reg <= 5'h00;
        end else if (sof) begin
            if (samp_cnt_reg == 5'h00) begin
                samp_cnt_reg <= (i_sample_div == 5'h00) ? 5'h00 : i_sample_div - 5'h01;
            end else begin
                samp_cnt_reg <= samp_cnt_reg - 5'h01;
            end
        end
    end
    assign sample_frame = (samp_cnt_reg == 5'h00);

    // RULE19 clamp ratio to 1..4
    always_comb begin
        if (i_oversample_ratio < 3'(OSR_MIN)) begin
            osr_eff = 3'(OSR_MIN);
        end else if (i_oversample_ratio > 3'(OSR_MAX)) begin
            osr_eff = 3'(OSR_MAX);
        end else begin
            osr_eff = i_oversample_ratio;
        end
    end

    // RULE2 sample frame starts analog
    assign start_a = sof && sample_frame;
    // RULE3 non-sample starts digital
    // RULE4 two digital sources only
    assign start_d = (sof && !sample_frame) || (phase_reg == FPS_PH_ANALOG && i_analog_end);
    assign o_start_analog = start_a;
    assign o_start_digital = start_d;

    // Phase sequencing
    // RULE5 analog end ends analog
    // RULE7 slow stop enters idle
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            phase_reg <= FPS_PH_IDLE;
        end else if (sof) begin
            phase_reg <= FPS_PH_WAIT;
        end else begin
            unique case (phase_reg)
                // RULE18 interrupt wakes idle
                FPS_PH_IDLE: begin
                    if (i_irq) begin
                        phase_reg <= FPS_PH_DIGITAL;
                    end
                end
                FPS_PH_WAIT: begin
                    if (pend_a_reg && i_osc_is_high) begin
                        phase_reg <= FPS_PH_ANALOG;
                    end else if (pend_d_reg && i_osc_is_high) begin
                        phase_reg <= FPS_PH_DIGITAL;
                    end
                end
                FPS_PH_ANALOG: begin
                    if (i_analog_end) begin
                        phase_reg <= FPS_PH_WAIT;
                    end
                end
                FPS_PH_DIGITAL: begin
                    if (i_cpu_stop && i_slow_clock_stop_sel && !i_irq) begin
                        phase_reg <= FPS_PH_IDLE;
                    end
                end
                default: begin
                    phase_reg <= FPS_PH_IDLE;
                end
            endcase
        end
    end

    // RULE6 pending triggers held until oscillator high
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pend_a_reg <= 1'b0;
            pend_d_reg <= 1'b0;
        end else begin
            if (start_a) begin
                pend_a_reg <= 1'b1;
            end else if (phase_reg == FPS_PH_WAIT && i_osc_is_high) begin
                pend_a_reg <= 1'b0;
            end
            if (start_d) begin
                pend_d_reg <= 1'b1;
            end else if (phase_reg == FPS_PH_WAIT && i_osc_is_high && !pend_a_reg) begin
                pend_d_reg <= 1'b0;
            end
        end
    end

    // RULE6 started pulses once oscillator switched
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            analog_started_reg <= 1'b0;
            digital_started_reg <= 1'b0;
        end else begin
            analog_started_reg <= !sof && phase_reg == FPS_PH_WAIT && pend_a_reg
                && i_osc_is_high;
            digital_started_reg <= !sof && phase_reg == FPS_PH_WAIT && !pend_a_reg
                && pend_d_reg && i_osc_is_high;
        end
    end
    assign o_analog_started = analog_started_reg;
    assign o_digital_started = digital_started_reg;

    // RULE20 request high speed at frame start
    // RULE8 high speed in active phases
    // RULE9 low speed selected for idle
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            osc_high_req_reg <= 1'b1;
            osc_low_req_reg <= 1'b0;
        end else if (sof) begin
            osc_high_req_reg <= 1'b1;
            osc_low_req_reg <= 1'b0;
        end else if (phase_reg == FPS_PH_DIGITAL && i_cpu_stop && i_slow_clock_stop_sel
                && !i_irq) begin
            osc_high_req_reg <= 1'b0;
            osc_low_req_reg <= 1'b1;
        end else if (phase_reg == FPS_PH_IDLE && i_irq) begin
            osc_high_req_reg <= 1'b1;
            osc_low_req_reg <= 1'b0;
        end
    end
    assign o_osc_high_req = osc_high_req_reg;
    assign o_osc_low_req = osc_low_req_reg;

    // RULE18 fast stop left on any interrupt
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            stopped_fast_reg <= 1'b0;
        end else if (i_irq) begin
            stopped_fast_reg <= 1'b0;
        end else if (i_cpu_stop && i_fast_clock_stop_sel) begin
            stopped_fast_reg <= 1'b1;
        end
    end

    // RULE13 CPU quiet in analog
    assign o_cpu_quiet = (phase_reg == FPS_PH_ANALOG) || stopped_fast_reg;
    // RULE14 analog low power in digital
    assign o_analog_lowpower = (phase_reg != FPS_PH_ANALOG);
    // RULE11 idle powers down
    assign o_power_down = (phase_reg == FPS_PH_IDLE);

    // RULE12 three axes plus chosen auxiliary
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            chan_en_reg <= 4'h0;
        end else if (start_a) begin
            chan_en_reg <= {(i_aux_sel == AUX_TEMP || i_aux_sel == AUX_EXT0
                || i_aux_sel == AUX_EXT1), 3'h7};
        end else if (phase_reg != FPS_PH_ANALOG && phase_reg != FPS_PH_WAIT) begin
            chan_en_reg <= 4'h0;
        end
    end
    assign o_chan_en = chan_en_reg;

    // RULE16 output every ratio sample frames
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            osr_cnt_reg <= 3'h0;
            output_ready_reg <= 1'b0;
        end else begin
            output_ready_reg <= 1'b0;
            if (phase_reg == FPS_PH_ANALOG && i_analog_end) begin
                if (osr_cnt_reg + 3'h1 >= osr_eff) begin
                    osr_cnt_reg <= 3'h0;
                    output_ready_reg <= 1'b1;
                end else begin
                    osr_cnt_reg <= osr_cnt_reg + 3'h1;
                end
            end
        end
    end
    assign o_output_ready = output_ready_reg;

    // RULE10 digital must finish before next frame
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            overrun_reg <= 1'b0;
        end else if (sof) begin
            overrun_reg <= (phase_reg == FPS_PH_DIGITAL) || (phase_reg == FPS_PH_ANALOG);
        end
    end
    assign o_digital_overrun = overrun_reg;

    // Assertions
    property p_start_a;
        @(posedge I_REF_CLK) disable iff (!I_ARST_N)
        o_start_analog |-> sof && sample_frame;
    endproperty
    a_start_a: assert property (p_start_a) else $error("analog start without sample sof"); // RULE2

    property p_start_d_nonsample;
        @(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (sof && !sample_frame) |-> o_start_digital;
    endproperty
    a_start_d_nonsample: assert property (p_start_d_nonsample) else $error("no digital start"); // RULE3

    property p_start_d_src;
        @(posedge I_REF_CLK) disable iff (!I_ARST_N)
        o_start_digital |-> sof || (phase_reg == FPS_PH_ANALOG && i_analog_end);
    endproperty
    a_start_d_src: assert property (p_start_d_src) else $error("bad digital source"); // RULE4

    property p_started_high;
        @(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (o_analog_started || o_digital_started) |-> $past(i_osc_is_high);
    endproperty
    a_started_high: assert property (p_started_high) else $error("started while slow"); // RULE6

    property p_sof_high_req;
        @(posedge I_REF_CLK) disable iff (!I_ARST_N)
        sof |=> o_osc_high_req && !o_osc_low_req;
    endproperty
    a_sof_high_req: assert property (p_sof_high_req) else $error("no high request"); // RULE20

    property p_quiet;
        @(posedge I_REF_CLK) disable iff (!I_ARST_N)
        phase_reg == FPS_PH_ANALOG |-> o_cpu_quiet && !o_analog_lowpower;
    endproperty
    a_quiet: assert property (p_quiet) else $error("cpu not quiet"); // RULE13

    property p_idle;
        @(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (phase_reg == FPS_PH_DIGITAL && i_cpu_stop && i_slow_clock_stop_sel && !i_irq && !sof)
            |=> o_power_down && o_osc_low_req;
    endproperty
    a_idle: assert property (p_idle) else $error("idle not entered"); // RULE7

    property p_irq_wake;
        @(posedge I_REF_CLK) disable iff (!I_ARST_N)
        i_irq |=> !stopped_fast_reg && !o_power_down;
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("stop kept after irq"); // RULE18

    property p_osr;
        @(posedge I_REF_CLK) disable iff (!I_ARST_N)
        osr_eff >= 3'(OSR_MIN) && osr_eff <= 3'(OSR_MAX);
    endproperty
    a_osr: assert property (p_osr) else $error("ratio out of range"); // RULE19

    c_analog: cover property (@(posedge I_REF_CLK) disable iff (!I_ARST_N) o_analog_started);
    c_digital: cover property (@(posedge I_REF_CLK) disable iff (!I_ARST_N) o_digital_started);
    c_idle: cover property (@(posedge I_REF_CLK) disable iff (!I_ARST_N) o_power_down ##1 sof);
    c_out: cover property (@(posedge I_REF_CLK) disable iff (!I_ARST_N) o_output_ready);
endmodule : fps_frame_phase_sequencer
`default_nettype wire

// File: fps_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module fps_partner_model (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_start_analog,
    input wire logic i_digital_started,
    input wire logic i_osc_high_req,
    input wire logic i_osc_low_req,
    input wire logic i_cpu_en,
    input wire logic [7:0] i_analog_delay,
    input wire logic [7:0] i_osc_delay,
    input wire logic [7:0] i_cpu_delay,
    output logic o_analog_end,
    output logic o_osc_is_high,
    output logic o_cpu_stop
);
    logic ana_busy_reg;
    logic [7:0] ana_cnt_reg;
    logic [7:0] osc_cnt_reg;
    logic cpu_busy_reg;
    logic [7:0] cpu_cnt_reg;
    // Analog front end: conversion time, then one end pulse
    // conversion end pulse
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ana_busy_reg <= 1'b0;
            ana_cnt_reg <= 8'h00;
            o_analog_end <= 1'b0;
        end else begin
            o_analog_end <= 1'b0;
            if (i_start_analog) begin
                ana_busy_reg <= 1'b1;
                ana_cnt_reg <= 8'h00;
            end else if (ana_busy_reg && ana_cnt_reg == i_analog_delay) begin
                o_analog_end <= 1'b1;
                ana_busy_reg <= 1'b0;
            end else if (ana_busy_reg) begin
                ana_cnt_reg <= ana_cnt_reg + 8'h01;
            end
        end
    end
    // Oscillator: slow switch to high speed, drops at once on low request
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_osc_is_high <= 1'b0;
            osc_cnt_reg <= 8'h00;
        end else if (i_osc_low_req && !i_osc_high_req) begin
            o_osc_is_high <= 1'b0;
            osc_cnt_reg <= 8'h00;
        end else if (i_osc_high_req && !o_osc_is_high) begin
            if (osc_cnt_reg >= i_osc_delay) begin
                o_osc_is_high <= 1'b1;
            end else begin
                osc_cnt_reg <= osc_cnt_reg + 8'h01;
            end
        end
    end
    // CPU: processing time, then a stop instruction
    // stop for idle
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cpu_busy_reg <= 1'b0;
            cpu_cnt_reg <= 8'h00;
            o_cpu_stop <= 1'b0;
        end else begin
            o_cpu_stop <= 1'b0;
            if (i_digital_started && i_cpu_en) begin
                cpu_busy_reg <= 1'b1;
                cpu_cnt_reg <= 8'h00;
            end else if (cpu_busy_reg && cpu_cnt_reg == i_cpu_delay) begin
                o_cpu_stop <= 1'b1;
                cpu_busy_reg <= 1'b0;
            end else if (cpu_busy_reg) begin
                cpu_cnt_reg <= cpu_cnt_reg + 8'h01;
            end
        end
    end
endmodule : fps_partner_model
`default_nettype wire

// File: frame_phase_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module frame_phase_sequencer_tb;
    import fps_pkg::*;
    localparam int FC = 50;
    logic clk, arst_n, enable, a_end, osc_hi, cpu_stop, slow_sel, fast_sel, irq, cpu_en;
    logic [4:0] sdiv;
    logic [2:0] oversample_ratio;
    logic [1:0] aux;
    logic [7:0] a_dly, o_dly, c_dly;
    logic st_a, st_d, a_started, d_started, hi_req, lo_req, quiet, a_lp, pdown, rdy, ovr;
    logic [3:0] chan;
    int fail_count, compares, cyc, last_sof, n_sof;
    fps_frame_phase_sequencer #(.FRAME_CYCLES(FC)) u_fps_frame_phase_sequencer (
        .I_REF_CLK(clk), .I_ARST_N(arst_n), .i_enable(enable), .i_sample_div(sdiv),
        .i_oversample_ratio(oversample_ratio), .i_aux_sel(aux), .i_analog_end(a_end),
        .i_osc_is_high(osc_hi), .i_cpu_stop(cpu_stop), .i_slow_clock_stop_sel(slow_sel),
        .i_fast_clock_stop_sel(fast_sel), .i_irq(irq), .o_start_analog(st_a),
        .o_start_digital(st_d), .o_analog_started(a_started), .o_digital_started(d_started),
        .o_osc_high_req(hi_req), .o_osc_low_req(lo_req), .o_cpu_quiet(quiet),
        .o_analog_lowpower(a_lp), .o_power_down(pdown), .o_chan_en(chan),
        .o_output_ready(rdy), .o_digital_overrun(ovr));
    fps_partner_model u_fps_partner_model (
        .i_clk(clk), .i_arst_n(arst_n), .i_start_analog(a_started), .i_digital_started(d_started),
        .i_osc_high_req(hi_req), .i_osc_low_req(lo_req), .i_cpu_en(cpu_en),
        .i_analog_delay(a_dly), .i_osc_delay(o_dly), .i_cpu_delay(c_dly),
        .o_analog_end(a_end), .o_osc_is_high(osc_hi), .o_cpu_stop(cpu_stop));
    // Clock generation
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string name);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    function automatic logic pick(input int sel);
        case (sel)
            0: return a_started;
            1: return d_started;
            2: return st_d;
            3: return pdown;
            5: return quiet & a_lp;
            default: return st_a | (st_d & ~a_end);
        endcase
    endfunction : pick
    // Bounded wait for a design event, sampled mid-cycle
    task automatic wait_for(input int sel, input int lim);
        int n;
        n = 0;
        @(negedge clk);
        while (pick(sel) !== 1'b1) begin
            n++;
            if (n > lim) begin
                fail_count++;
                $display("BAD wait_%0d expected 1 seen 0", sel);
                end_sim();
            end
            @(negedge clk);
        end
    endtask : wait_for
    // Frame spacing and started qualification monitor
    always @(negedge clk) begin
        cyc++;
        if (pick(4) === 1'b1) begin
            if (n_sof > 0) check(cyc - last_sof, FC, "frame_gap");
            last_sof = cyc;
            n_sof++;
        end
        if (a_started === 1'b1 || d_started === 1'b1) check(osc_hi, 1, "osc_hi");
    end
    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        enable <= 1'b0;
        irq <= 1'b0;
        cpu_en <= 1'b1;
        slow_sel <= 1'b1;
        fast_sel <= 1'b0;
        sdiv <= 5'h01;
        oversample_ratio <= 3'h1;
        aux <= 2'h0;
        repeat (6) @(posedge clk);
        n_sof = 0;
        arst_n <= 1'b1;
        @(posedge clk);
        enable <= 1'b1;
    endtask : do_reset
    task automatic t_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        @(negedge clk);
        check(pdown, 1, "pdown");
        check(hi_req, 1, "hi_req");
        check(a_lp, 1, "a_lp");
        check({st_a, st_d, lo_req, d_started}, 0, "idle_outs");
        do_reset();
        $display("reset test done");
    endtask : t_reset
    task automatic t_sample();
        do_reset();
        wait_for(4, 2 * FC);
        check({st_a, st_d}, 2'h2, "sof_start");
        wait_for(0, 20);
        check(quiet, 1, "quiet");
        wait_for(2, 20);
        check(a_end, 1, "digital_cause");
        wait_for(1, 20);
        check({quiet, a_lp}, 2'h1, "digital_power");
        wait_for(3, 20);
        check(lo_req, 1, "lo_req");
        check(ovr, 0, "ovr");
        wait_for(4, FC);
        @(negedge clk);
        check(hi_req, 1, "hi_req");
        check(pdown, 0, "pdown");
        wait_for(0, 20);
        $display("sample frame test done");
    endtask : t_sample
    task automatic t_nonsample();
        int n;
        int m;
        do_reset();
        sdiv <= 5'h02;
        n = 0;
        m = 0;
        wait_for(4, 2 * FC);
        repeat (4) begin
            wait_for(4, FC);
            n += st_a;
            m += st_d;
        end
        check(n, 2, "sample_count");
        check(m, 2, "digital_count");
        $display("non-sample test done");
    endtask : t_nonsample
    task automatic t_oversample();
        int n;
        for (int r = 1; r <= 4; r++) begin
            do_reset();
            oversample_ratio <= 3'(r);
            n = 0;
            repeat (2 * r * FC + 30) begin
                @(negedge clk);
                n += rdy;
            end
            check(n, 2, "ready_count");
        end
        $display("oversample test done");
    endtask : t_oversample
    task automatic t_aux();
        for (int s = 0; s < 4; s++) begin
            do_reset();
            aux <= 2'(s);
            wait_for(0, 3 * FC);
            @(negedge clk);
            check(chan, {s != 3, 3'h7}, "chan_en");
        end
        $display("aux test done");
    endtask : t_aux
    task automatic t_irq();
        do_reset();
        irq <= 1'b1;
        wait_for(1, 3 * FC);
        repeat (10) @(negedge clk);
        check(pdown, 0, "stop_refused");
        @(posedge clk);
        irq <= 1'b0;
        wait_for(3, 3 * FC);
        @(posedge clk);
        irq <= 1'b1;
        repeat (2) @(negedge clk);
        check(pdown, 0, "irq_wake");
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_fast();
        do_reset();
        slow_sel <= 1'b0;
        fast_sel <= 1'b1;
        wait_for(5, 2 * FC);
        check(quiet, 1, "fast_quiet");
        check(pdown, 0, "fast_no_idle");
        @(posedge clk);
        irq <= 1'b1;
        repeat (2) @(negedge clk);
        check(quiet, 0, "fast_wake");
        $display("fast stop test done");
    endtask : t_fast
    task automatic t_overrun();
        do_reset();
        cpu_en <= 1'b0;
        wait_for(4, 2 * FC);
        wait_for(4, FC);
        repeat (2) @(negedge clk);
        check(ovr, 1, "overrun");
        $display("overrun test done");
    endtask : t_overrun
    initial begin
        {arst_n, enable, irq, cpu_en, slow_sel, fast_sel} = 6'h02;
        {sdiv, oversample_ratio, aux} = 10'h024;
        a_dly = 8'h04;
        o_dly = 8'h06;
        c_dly = 8'h03;
        fail_count = 0;
        compares = 0;
        cyc = 0;
        n_sof = 0;
        last_sof = 0;
        do_reset();
        t_reset();
        t_sample();
        t_nonsample();
        t_oversample();
        t_aux();
        t_irq();
        t_fast();
        t_overrun();
        end_sim();
    end
endmodule : frame_phase_sequencer_tb
`default_nettype wire
